// *** include/hbridge_ctrl_pkg.sv ***
// Package for the H-bridge driver control register bank.
// Assumes a 100 MHz system clock and a 16-bit serial command frame.
package hbridge_ctrl_pkg;
   // Serial frame layout.
   localparam int unsigned FRAME_BITS   = 16;
   localparam int unsigned RW_BIT       = 15;
   localparam int unsigned ADDR_MSB     = 14;
   localparam int unsigned ADDR_LSB     = 11;
   localparam int unsigned DATA_MSB     = 7;
   // Register addresses.
   localparam logic [3:0] ADDR_FAULT_STATUS  = 4'h0;
   localparam logic [3:0] ADDR_MONITOR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_MAIN_CONTROL  = 4'h2;
   localparam logic [3:0] ADDR_GATE_WD       = 4'h3;
   localparam logic [3:0] ADDR_OC_MONITOR    = 4'h4;
   // Lock field position and keys.
   localparam int unsigned LOCK_LSB       = 3;
   localparam int unsigned LOCK_MSB       = 5;
   localparam logic [2:0]  LOCK_KEY       = 3'h6;
   localparam logic [2:0]  UNLOCK_KEY     = 3'h3;
   // Main control field positions.
   localparam int unsigned IN_ONE_BIT     = 2;
   localparam int unsigned IN_TWO_BIT     = 1;
   localparam int unsigned FAULT_CLR_BIT  = 0;
   // Gate current and watchdog field positions.
   localparam int unsigned DEAD_LSB       = 6;
   localparam int unsigned WD_ON_BIT      = 5;
   localparam int unsigned WD_SEL_LSB     = 3;
   localparam int unsigned GATE_CODE_LSB  = 0;
   // Overcurrent monitor control field positions.
   localparam int unsigned CLAMP_BIT      = 7;
   localparam int unsigned OC_SEL_LSB     = 4;
   localparam int unsigned MON_OFF_LSB    = 0;
   // Reset values.
   localparam logic [7:0] MAIN_RESET      = 8'h18;
   localparam logic [7:0] GATE_WD_RESET   = 8'h07;
   localparam logic [7:0] OC_MON_RESET    = 8'h70;
   // Write mask of the main control register; the clear bit never stores.
   localparam logic [7:0] MAIN_WMASK      = 8'hFE;
endpackage : hbridge_ctrl_pkg

// *** core/hbridge_driver_control_regs.sv ***
// Control register bank of an H-bridge gate driver with its serial command port.
// Assumes the serial pins are asynchronous to mclk and that sclk is far slower than mclk.
`timescale 1ns/100ps
`default_nettype none
module hbridge_driver_control_regs (
   input  wire logic       mclk,             // System clock, 100 MHz.
   input  wire logic       nrst,             // Asynchronous reset, active low.
   input  wire logic       sclk,             // Serial clock from host.
   input  wire logic       scsN,             // Serial chip select, active low.
   input  wire logic       sdi,              // Serial data in.
   output var  logic       sdo,              // Serial data out.
   output var  logic       sdoOeN,           // Serial data out enable, low while driving.
   input  wire logic       bridgeInOnePin,   // External bridge input one pin.
   input  wire logic       bridgeInTwoPin,   // External bridge input two pin.
   input  wire logic [7:0] faultStatus,      // Fault status byte from the protection logic.
   input  wire logic [7:0] monitorStatus,    // Per-FET fault status byte.
   output var  logic       bridgeInOne,      // Effective bridge input one.
   output var  logic       bridgeInTwo,      // Effective bridge input two.
   output var  logic       faultClear,       // One-cycle fault clear pulse.
   output var  logic       locked,           // Register lock state.
   output var  logic [1:0] deadTimeSel,      // Dead time selection.
   output var  logic       watchdogOn,       // Watchdog enable.
   output var  logic [1:0] watchdogTimeoutSel, // Watchdog timeout selection.
   output var  logic [2:0] gateCurrentCode,  // Gate drive current code.
   output var  logic       senseOutputClamp, // Sense output clamp.
   output var  logic [2:0] overcurrentThresholdSel, // Overcurrent trip level.
   output var  logic [3:0] monitorOff        // Per-FET monitor disables {H2,L2,H1,L1}.
);
   logic [2:0]  sclkSync;
   logic [2:0]  csSync;
   logic [1:0]  sdiSync;
   logic        sclkRise;
   logic        sclkFall;
   logic        csActive;
   logic [15:0] shiftIn_reg;
   logic [4:0]  bitCount_reg;
   logic [7:0]  shiftOut_reg;
   logic [7:0]  mainCtl_reg;
   logic [7:0]  gateWd_reg;
   logic [7:0]  ocMon_reg;
   logic        lock_reg;
   logic [3:0]  frameAddr;
   logic [7:0]  frameData;
   logic        frameDone;
   logic        frameWrite;
   logic [7:0]  readValue;
   logic [3:0]  nextAddr;
   logic        lockKeySeen;
   logic        unlockKeySeen;
   logic        regsWritable;

   // Two-stage synchronisers; the third stage of sclk and select only feeds edge detection.
   // Each chain resets to the idle level of its pin, so no false edge follows reset.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sclkSync <= 3'h0;
      end else begin
         sclkSync <= {sclkSync[1:0], sclk};
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         csSync <= 3'h7;
      end else begin
         csSync <= {csSync[1:0], scsN};
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sdiSync <= 2'h0;
      end else begin
         sdiSync <= {sdiSync[0], sdi};
      end
   end

   assign sclkRise = sclkSync[1] & ~sclkSync[2];
   assign sclkFall = ~sclkSync[1] & sclkSync[2];
   assign csActive = ~csSync[1];
   // Address bits as they will stand once the fifth bit is shifted in.
   assign nextAddr = {shiftIn_reg[2:0], sdiSync[1]};

   // Reply source for the address being shifted in; the status bytes are only ever read.
   always_comb begin
      case (nextAddr)
         hbridge_ctrl_pkg::ADDR_FAULT_STATUS:   readValue = faultStatus;
         hbridge_ctrl_pkg::ADDR_MONITOR_STATUS: readValue = monitorStatus;
         hbridge_ctrl_pkg::ADDR_MAIN_CONTROL:   readValue = mainCtl_reg;
         hbridge_ctrl_pkg::ADDR_GATE_WD:        readValue = gateWd_reg;
         hbridge_ctrl_pkg::ADDR_OC_MONITOR:     readValue = ocMon_reg;
         default:                               readValue = 8'h00;
      endcase
   end

   // Bit count of the frame; it runs past 16 and saturates, so an overlong frame is refused as well.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         bitCount_reg <= 5'h00;
      end else if (!csActive) begin
         bitCount_reg <= 5'h00;
      end else if (sclkRise && !(&bitCount_reg)) begin
         bitCount_reg <= bitCount_reg + 5'h01;
      end
   end

   // Input shift register; sdi is taken on the rising sclk edge, first bit first.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         shiftIn_reg <= 16'h0000;
      end else if (csActive && sclkRise && bitCount_reg < 5'(hbridge_ctrl_pkg::FRAME_BITS)) begin
         shiftIn_reg <= {shiftIn_reg[14:0], sdiSync[1]};
      end
   end

   // Reply: the addressed register is captured once the address is known, before any write.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         shiftOut_reg <= 8'h00;
      end else if (csActive && sclkRise && bitCount_reg == 5'h04) begin
         shiftOut_reg <= readValue;
      // The top data bit stands from the eighth rise on; shifting starts at the fall after the ninth rise.
      end else if (csActive && sclkFall && bitCount_reg > 5'h08) begin
         shiftOut_reg <= {shiftOut_reg[6:0], 1'b0};
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sdo    <= 1'b0;
         sdoOeN <= 1'b1;
      end else begin
         sdoOeN <= ~csActive;
         sdo    <= (bitCount_reg > 5'h07) ? shiftOut_reg[7] : 1'b0;
      end
   end

   // A frame takes effect only when exactly 16 bits arrived before deselect.
   // Deselect is seen on the synchronised stages only; the count is still intact in that cycle.
   assign frameDone  = csSync[1] & ~csSync[2] & (bitCount_reg == 5'(hbridge_ctrl_pkg::FRAME_BITS));
   assign frameWrite = frameDone & ~shiftIn_reg[hbridge_ctrl_pkg::RW_BIT];
   assign frameAddr  = shiftIn_reg[hbridge_ctrl_pkg::ADDR_MSB:hbridge_ctrl_pkg::ADDR_LSB];
   assign frameData  = shiftIn_reg[hbridge_ctrl_pkg::DATA_MSB:0];

   assign lockKeySeen   = frameData[hbridge_ctrl_pkg::LOCK_MSB:hbridge_ctrl_pkg::LOCK_LSB]
                          == hbridge_ctrl_pkg::LOCK_KEY;
   assign unlockKeySeen = frameData[hbridge_ctrl_pkg::LOCK_MSB:hbridge_ctrl_pkg::LOCK_LSB]
                          == hbridge_ctrl_pkg::UNLOCK_KEY;
   assign regsWritable  = frameWrite & ~lock_reg;

   // Main control stays writable while locked; the clear bit never stores.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mainCtl_reg <= hbridge_ctrl_pkg::MAIN_RESET;
      end else if (frameWrite && frameAddr == hbridge_ctrl_pkg::ADDR_MAIN_CONTROL) begin
         mainCtl_reg <= frameData & hbridge_ctrl_pkg::MAIN_WMASK;
      end
   end

   // Lock flag: only the key matching the present state moves it; other values leave it alone.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         lock_reg <= 1'b0;
      end else if (frameWrite && frameAddr == hbridge_ctrl_pkg::ADDR_MAIN_CONTROL) begin
         if (!lock_reg && lockKeySeen) begin
            lock_reg <= 1'b1;
         end else if (lock_reg && unlockKeySeen) begin
            lock_reg <= 1'b0;
         end
      end
   end

   // Gate current and watchdog settings; a write while locked is dropped silently.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         gateWd_reg <= hbridge_ctrl_pkg::GATE_WD_RESET;
      end else if (regsWritable && frameAddr == hbridge_ctrl_pkg::ADDR_GATE_WD) begin
         gateWd_reg <= frameData;
      end
   end

   // Overcurrent monitor settings; a write while locked is dropped silently.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ocMon_reg <= hbridge_ctrl_pkg::OC_MON_RESET;
      end else if (regsWritable && frameAddr == hbridge_ctrl_pkg::ADDR_OC_MONITOR) begin
         ocMon_reg <= frameData;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         faultClear <= 1'b0;
      end else begin
         faultClear <= frameWrite && frameAddr == hbridge_ctrl_pkg::ADDR_MAIN_CONTROL
                       && frameData[hbridge_ctrl_pkg::FAULT_CLR_BIT];
      end
   end

   assign bridgeInOne = mainCtl_reg[hbridge_ctrl_pkg::IN_ONE_BIT] | bridgeInOnePin;
   assign bridgeInTwo = mainCtl_reg[hbridge_ctrl_pkg::IN_TWO_BIT] | bridgeInTwoPin;
   assign locked      = lock_reg;
   assign deadTimeSel = gateWd_reg[hbridge_ctrl_pkg::DEAD_LSB +: 2];
   assign watchdogOn  = gateWd_reg[hbridge_ctrl_pkg::WD_ON_BIT];
   assign watchdogTimeoutSel = gateWd_reg[hbridge_ctrl_pkg::WD_SEL_LSB +: 2];
   assign gateCurrentCode    = gateWd_reg[hbridge_ctrl_pkg::GATE_CODE_LSB +: 3];
   assign senseOutputClamp   = ocMon_reg[hbridge_ctrl_pkg::CLAMP_BIT];
   assign overcurrentThresholdSel = ocMon_reg[hbridge_ctrl_pkg::OC_SEL_LSB +: 3];
   assign monitorOff         = ocMon_reg[hbridge_ctrl_pkg::MON_OFF_LSB +: 4];
endmodule : hbridge_driver_control_regs
`default_nettype wire

// *** dv/hbridge_ctrl_props.sv ***
// Port checker for the H-bridge control register bank.
// Assumes it is bound to the bank and sees only the bank's ports.
`timescale 1ns/100ps
`default_nettype none
module hbridge_ctrl_props (
   input wire logic       mclk,                    // System clock.
   input wire logic       nrst,                    // Reset, active low.
   input wire logic       sclk,                    // Serial clock.
   input wire logic       scsN,                    // Chip select, active low.
   input wire logic       sdi,                     // Serial data in.
   input wire logic       sdo,                     // Serial data out.
   input wire logic       sdoOeN,                  // Serial out enable, active low.
   input wire logic       bridgeInOnePin,          // Bridge input one pin.
   input wire logic       bridgeInTwoPin,          // Bridge input two pin.
   input wire logic       bridgeInOne,             // Effective bridge input one.
   input wire logic       bridgeInTwo,             // Effective bridge input two.
   input wire logic       faultClear,              // Fault clear pulse.
   input wire logic       locked,                  // Lock state.
   input wire logic       watchdogOn,              // Watchdog enable.
   input wire logic       senseOutputClamp,        // Sense output clamp.
   input wire logic [7:0] faultStatus,             // Fault status byte.
   input wire logic [7:0] monitorStatus,           // Per-FET status byte.
   input wire logic [1:0] deadTimeSel,             // Dead time selection.
   input wire logic [1:0] watchdogTimeoutSel,      // Watchdog timeout selection.
   input wire logic [2:0] gateCurrentCode,         // Gate drive current code.
   input wire logic [2:0] overcurrentThresholdSel, // Overcurrent trip level.
   input wire logic [3:0] monitorOff               // Monitor disables.
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   wire logic [15:0] cfg = {deadTimeSel, watchdogOn, watchdogTimeoutSel, gateCurrentCode,
                            senseOutputClamp, overcurrentThresholdSel, monitorOff};
   a_in_one_or: assert property (bridgeInOnePin |-> bridgeInOne)
      else $error("bridge input one ignores its pin");
   a_in_two_or: assert property (bridgeInTwoPin |-> bridgeInTwo)
      else $error("bridge input two ignores its pin");
   a_clear_single: assert property (faultClear |=> !faultClear)
      else $error("fault clear longer than one cycle");
   a_clear_idle: assert property (faultClear |-> scsN && sdoOeN)
      else $error("fault clear inside a frame");
   a_cfg_frame_hold: assert property (!scsN && $past(!scsN, 4) |-> $stable(cfg))
      else $error("settings moved inside a frame");
   a_lock_at_end: assert property ($changed(locked) |-> scsN)
      else $error("lock moved inside a frame");
   a_oe_on_select: assert property ($fell(scsN) |-> ##[1:4] !sdoOeN)
      else $error("reply not driven after select");
   a_oe_on_release: assert property ($rose(scsN) |-> ##[1:4] sdoOeN)
      else $error("reply still driven after release");
   a_reset_cfg: assert property ($rose(nrst) |-> cfg == 16'h0770 && !locked)
      else $error("settings wrong after reset");
endmodule : hbridge_ctrl_props
bind hbridge_driver_control_regs hbridge_ctrl_props props (.mclk, .nrst, .sclk, .scsN, .sdi, .sdo, .sdoOeN,
   .bridgeInOnePin, .bridgeInTwoPin, .bridgeInOne, .bridgeInTwo, .faultClear, .locked, .watchdogOn,
   .senseOutputClamp, .faultStatus, .monitorStatus, .deadTimeSel, .watchdogTimeoutSel, .gateCurrentCode,
   .overcurrentThresholdSel, .monitorOff);
`default_nettype wire

// *** dv/spi_host_model.sv ***
// Serial host model: sends one 16-bit command per frame and collects the reply byte.
// Assumes mclk at 100 MHz; the serial clock runs at 160 ns only inside frames.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
   input  wire logic mclk,   // Pacing clock.
   output var  logic sclk,   // Serial clock, idle low.
   output var  logic scsN,   // Chip select, active low.
   output var  logic sdi,    // Serial data to the device.
   input  wire logic sdo,    // Serial data from the device.
   input  wire logic sdoOeN  // Low while the device drives sdo.
);
   initial sclk = 1'b0;
   initial scsN = 1'b1;
   initial sdi = 1'b0;
   // A frame shorter than 16 bits is cut off early so that the device must drop it.
   task automatic xfer(input logic [15:0] cmd, input int nbits, output logic [7:0] rsp);
      @(negedge mclk) scsN = 1'b0;
      sdi = cmd[15];
      for (int i = 15; i >= 16 - nbits; i--) begin
         repeat (8) @(negedge mclk);
         if (i < 8) rsp[i] = sdoOeN ? ~sdo : sdo;
         sclk = 1'b1;
         repeat (8) @(negedge mclk);
         sclk = 1'b0;
         if (i > 0) sdi = cmd[i-1];
      end
      repeat (8) @(negedge mclk);
      scsN = 1'b1;
      sdi = ~sdi;
      repeat (10) @(negedge mclk);
   endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the H-bridge control register bank.
// Assumes the serial host model drives the link; pins and status bytes come from the bench.
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic mclk = 1'b0, nrst = 1'b0, bridgeInOnePin = 1'b0, bridgeInTwoPin = 1'b0;
   logic [7:0] faultStatus = 8'h00, monitorStatus = 8'h00, rsp, d;
   logic [7:0] cur [2] = '{8'h07, 8'h70};
   logic [7:0] rstv [3] = '{8'h18, 8'h07, 8'h70};
   logic [7:0] lk [4] = '{8'h34, 8'h0A, 8'h18, 8'h28};
   wire logic sclk, scsN, sdi, sdo, sdoOeN, bridgeInOne, bridgeInTwo, faultClear, locked, watchdogOn, senseOutputClamp;
   wire logic [1:0] deadTimeSel, watchdogTimeoutSel;
   wire logic [2:0] gateCurrentCode, overcurrentThresholdSel;
   wire logic [3:0] monitorOff;
   wire logic [7:0] gateF = {deadTimeSel, watchdogOn, watchdogTimeoutSel, gateCurrentCode};
   wire logic [7:0] monF = {senseOutputClamp, overcurrentThresholdSel, monitorOff};
   int error_cnt = 0, n_compared = 0, clrCnt = 0, n;
   always #5 mclk = ~mclk;
   always @(posedge mclk) if (faultClear === 1'b1) clrCnt++;
   hbridge_driver_control_regs dut (.mclk, .nrst, .sclk, .scsN, .sdi, .sdo, .sdoOeN, .bridgeInOnePin,
      .bridgeInTwoPin, .faultStatus, .monitorStatus, .bridgeInOne, .bridgeInTwo, .faultClear, .locked,
      .deadTimeSel, .watchdogOn, .watchdogTimeoutSel, .gateCurrentCode, .senseOutputClamp,
      .overcurrentThresholdSel, .monitorOff);
   spi_host_model host (.mclk, .sclk, .scsN, .sdi, .sdo, .sdoOeN);
   function automatic logic [15:0] cmd(logic r, logic [3:0] a, logic [7:0] v);
      return {r, a, 3'h0, v};
   endfunction : cmd
   task automatic xf(logic r, logic [3:0] a, logic [7:0] v, int nb = 16);
      host.xfer(cmd(r, a, v), nb, rsp);
   endtask : xf
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   initial begin
      #1000000;
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h07845e60));
      repeat (20) @(negedge mclk);
      nrst = 1'b1;
      repeat (3) @(negedge mclk);
      for (int a = 2; a < 5; a++) begin
         xf(1'b1, 4'(a), 8'h00);
         chk("reset value", rstv[a-2], rsp);
      end
      for (int i = 0; i < 8; i++) begin
         d = (i < 2) ? 8'hFF : 8'($urandom);
         xf(1'b0, 4'(3 + i % 2), d);
         chk("write reply", cur[i%2], rsp);
         cur[i%2] = d;
         chk("gate fields", cur[0], gateF);
         chk("monitor fields", cur[1], monF);
      end
      faultStatus = 8'($urandom);
      monitorStatus = 8'($urandom);
      xf(1'b1, 4'h0, 8'h00);
      chk("fault status", faultStatus, rsp);
      xf(1'b1, 4'h1, 8'h00);
      chk("monitor status", monitorStatus, rsp);
      for (int k = 0; k < 16; k++) begin
         xf(1'b0, 4'h2, 8'h18 | {5'h00, k[1:0], 1'b0});
         bridgeInOnePin = k[2];
         bridgeInTwoPin = k[3];
         @(negedge mclk);
         chk("bridge inputs", {k[1] | k[2], k[0] | k[3]}, {bridgeInOne, bridgeInTwo});
      end
      n = clrCnt;
      xf(1'b0, 4'h2, 8'h19);
      chk("clear pulses", 16'h0001, 16'(clrCnt - n));
      xf(1'b1, 4'h2, 8'h00);
      chk("main readback", 8'h18, rsp);
      bridgeInOnePin = 1'b0;
      bridgeInTwoPin = 1'b0;
      for (int i = 0; i < 4; i++) begin
         xf(1'b0, 4'h2, lk[i]);
         chk("lock state", 16'(i < 2), 16'(locked));
         chk("bridge soft bits", lk[i][2:1], {bridgeInOne, bridgeInTwo});
         xf(1'b0, 4'h3, ~cur[0]);
         if (i >= 2) cur[0] = ~cur[0];
         chk("gate fields", cur[0], gateF);
      end
      xf(1'b0, 4'h3, ~cur[0], 12);
      chk("cut frame", cur[0], gateF);
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
